// ===== rtl/dcp_pkg.sv
// Package of constants for the dual channel pulse width modulator.
// Behaviour
// [RULE1] One 8-bit prescaler and one 8-bit counter serve both channels, so both share one period.
// [RULE2] Each prescaler tick steps the shared counter through 0 to 254 and then back to 0.
// [RULE3] The prescaler divides its input by the reload value plus one, one tick per division.
// [RULE4] The prescaler input is the system clock halved, so a period is 2*(reload+1)*255 clocks.
// [RULE5] A channel output is low while its duty value is greater than the counter.
// [RULE6] A channel output is high while its duty value is equal to or less than the counter.
// [RULE7] The duty ratio is the 8-bit duty value over 255, from 0/255 to 255/255.
// [RULE8] Duty 00H keeps the output high and duty FFH keeps it low, as the counter never hits 255.
// [RULE9] A new duty value acts on the comparison at once, not at the end of the period.
// [RULE10] Reading the prescaler register returns the reload value, never the running count.
// [RULE11] The two outputs are dedicated pins with no other function shared onto them.
// [RULE12] Reset clears prescaler, counter, reload and both duty values, leaving outputs high.
package dcp_pkg;

  localparam int DCP_DW = 8;
  localparam int DCP_NCH = 2;
  localparam int DCP_AW = 12;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [7:0] DCP_IDX_DUTY0 = 8'hFC;
  localparam logic [7:0] DCP_IDX_DUTY1 = 8'hFD;
  localparam logic [7:0] DCP_IDX_RELOAD = 8'hFE;
  localparam logic [DCP_AW-1:0] DCP_ADDR_DUTY0 = {2'h0, DCP_IDX_DUTY0, 2'h0};
  localparam logic [DCP_AW-1:0] DCP_ADDR_DUTY1 = {2'h0, DCP_IDX_DUTY1, 2'h0};
  localparam logic [DCP_AW-1:0] DCP_ADDR_RELOAD = {2'h0, DCP_IDX_RELOAD, 2'h0};

  // The counter runs modulo 255, so its last value is 254.
  localparam logic [DCP_DW-1:0] DCP_CNT_LAST = 8'hFE;
  localparam logic [DCP_DW-1:0] DCP_RST_BYTE = 8'h00;
  localparam logic [31:0] DCP_RD_NONE = 32'h0000_0000;

  // Full period in system clocks for a given reload: 2 * (reload + 1) * 255.
  localparam int DCP_CLK_DIV = 2;
  localparam int DCP_CNT_MOD = 255;

endpackage : dcp_pkg

// ===== rtl/dcp_pwm.sv
// Dual channel pulse width modulator with an APB register slave.
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/100ps

module dcp_pwm
  import dcp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [DCP_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [DCP_NCH-1:0] duty_output
);

  ////////////////////////////////////////////////////////////////////////////
  // State.

  typedef struct packed {
    logic half;
    logic [DCP_DW-1:0] presc;
    logic [DCP_DW-1:0] cnt;
    logic [DCP_DW-1:0] reload;
    logic [DCP_NCH-1:0][DCP_DW-1:0] duty;
    logic [DCP_NCH-1:0] out;
    logic [31:0] rdata;
    logic ready;
    logic err;
  } dcp_state_t;

  dcp_state_t st_reg;
  dcp_state_t st_next;

  logic access;
  logic commit;
  logic hit_duty0;
  logic hit_duty1;
  logic hit_reload;
  logic mapped;
  logic tick;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode.

  // A request is answered one cycle into the access phase, and takes
  // effect on the edge where pready is seen high.
  assign access = psel && penable;
  assign commit = access && st_reg.ready;
  assign hit_duty0 = (paddr == DCP_ADDR_DUTY0);
  assign hit_duty1 = (paddr == DCP_ADDR_DUTY1);
  assign hit_reload = (paddr == DCP_ADDR_RELOAD);
  assign mapped = hit_duty0 || hit_duty1 || hit_reload;

  // The prescaler advances only on every second system clock.
  assign tick = st_reg.half && (st_reg.presc >= st_reg.reload); // RULE3 RULE4

  ////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    st_next = st_reg;

    st_next.half = ~st_reg.half; // RULE4
    if (st_reg.half) begin
      // Lowering the reload below the running count wraps at once
      // instead of running up through 255.
      if (st_reg.presc >= st_reg.reload) begin
        st_next.presc = DCP_RST_BYTE; // RULE3
      end else begin
        st_next.presc = st_reg.presc + 8'h01; // RULE3
      end
    end

    // One shared counter keeps both channels on one period.
    if (tick) begin
      if (st_reg.cnt == DCP_CNT_LAST) begin
        st_next.cnt = DCP_RST_BYTE; // RULE1 RULE2
      end else begin
        st_next.cnt = st_reg.cnt + 8'h01; // RULE2
      end
    end

    if (access && !st_reg.ready) begin
      st_next.ready = 1'b1;
      st_next.err = !mapped;
      st_next.rdata = DCP_RD_NONE;
      if (!pwrite) begin
        if (hit_duty0) begin
          st_next.rdata = {24'h000000, st_reg.duty[0]};
        end else if (hit_duty1) begin
          st_next.rdata = {24'h000000, st_reg.duty[1]};
        end else if (hit_reload) begin
          st_next.rdata = {24'h000000, st_reg.reload}; // RULE10
        end
      end
    end else begin
      st_next.ready = 1'b0;
      st_next.err = 1'b0;
    end

    if (commit && pwrite) begin
      if (hit_duty0) begin
        st_next.duty[0] = pwdata[DCP_DW-1:0]; // RULE7
      end
      if (hit_duty1) begin
        st_next.duty[1] = pwdata[DCP_DW-1:0]; // RULE7
      end
      if (hit_reload) begin
        st_next.reload = pwdata[DCP_DW-1:0];
      end
    end

    // Comparing next values lets a fresh duty write show on the same edge.
    for (int ch = 0; ch < DCP_NCH; ch++) begin
      st_next.out[ch] = !(st_next.duty[ch] > st_next.cnt); // RULE5 RULE6 RULE8 RULE9
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers.

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg.half <= 1'b0;
      st_reg.presc <= DCP_RST_BYTE; // RULE12
      st_reg.cnt <= DCP_RST_BYTE; // RULE12
      st_reg.reload <= DCP_RST_BYTE; // RULE12
      st_reg.duty <= '0; // RULE12
      st_reg.out <= '1; // RULE12
      st_reg.rdata <= DCP_RD_NONE;
      st_reg.ready <= 1'b0;
      st_reg.err <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // The pins carry the compare result only; nothing else is muxed onto them.
  assign duty_output = st_reg.out; // RULE11
  assign prdata = st_reg.rdata;
  assign pready = st_reg.ready;
  assign pslverr = st_reg.err;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking dcp_cb @(posedge pclk);
  endclocking

  default disable iff (!presetn);

  // Shared counter. Both channels read this one value, which keeps them in step.
  a_cnt_range: assert property ( // RULE2
    st_reg.cnt <= DCP_CNT_LAST)
    else $error("Shared counter left the 0 to 254 range.");

  a_cnt_wrap: assert property ( // RULE2
    tick && st_reg.cnt == DCP_CNT_LAST |=> st_reg.cnt == 8'h00)
    else $error("Counter did not wrap to zero after 254.");

  a_cnt_hold: assert property ( // RULE1
    !tick |=> st_reg.cnt == $past(st_reg.cnt))
    else $error("Counter moved without a prescaler tick.");

  a_cnt_step: assert property ( // RULE2
    tick && st_reg.cnt != DCP_CNT_LAST |=> st_reg.cnt == $past(st_reg.cnt) + 8'h01)
    else $error("Counter did not step by one on a tick.");

  a_cnt_tick_only: assert property ( // RULE1
    $changed(st_reg.cnt) |-> $past(tick))
    else $error("Counter changed without a tick on the edge before.");

  // Prescaler. The timing windows below assume the reload is not rewritten inside
  // them; a rewrite there is legal use that these checks do not model.
  a_presc_steady: assert property ( // RULE3
    st_reg.half && st_reg.reload == 8'h02 && st_reg.presc == 8'h00
    |-> !tick ##1 !tick ##1 !tick ##1 !tick ##1 tick)
    else $error("Prescaler did not divide by reload plus one.");

  a_half_toggle: assert property ( // RULE4
    st_reg.half |=> !st_reg.half)
    else $error("Prescaler input is not the halved clock.");

  a_presc_wrap: assert property ( // RULE3
    st_reg.half && st_reg.presc >= st_reg.reload |=> st_reg.presc == 8'h00)
    else $error("Prescaler did not restart after reaching the reload.");

  a_presc_step: assert property ( // RULE3
    st_reg.half && st_reg.presc < st_reg.reload
    |=> st_reg.presc == $past(st_reg.presc) + 8'h01)
    else $error("Prescaler did not step by one on its input clock.");

  a_presc_idle: assert property ( // RULE4
    !st_reg.half |=> $stable(st_reg.presc))
    else $error("Prescaler moved on the idle half of the system clock.");

  a_tick_half: assert property ( // RULE4
    tick |-> st_reg.half)
    else $error("Tick outside the halved input clock.");

  a_tick_gap: assert property ( // RULE4
    tick |=> !tick)
    else $error("Two ticks on adjacent system clocks.");

  a_tick_rate0: assert property ( // RULE4
    tick && st_reg.reload == 8'h00 ##1 st_reg.reload == 8'h00 [*2] |-> tick)
    else $error("Reload zero did not tick every second clock.");

  a_tick_rate1: assert property ( // RULE4
    tick && st_reg.reload == 8'h01 ##1 st_reg.reload == 8'h01 [*4] |-> tick)
    else $error("Reload one did not tick every fourth clock.");

  // Channel outputs.
  a_ch0_low: assert property ( // RULE5
    st_reg.duty[0] > st_reg.cnt |-> !duty_output[0])
    else $error("Channel 0 high while duty exceeds counter.");

  a_ch1_high: assert property ( // RULE6
    st_reg.duty[1] <= st_reg.cnt |-> duty_output[1])
    else $error("Channel 1 low while duty is at or below counter.");

  a_ffh_low: assert property ( // RULE8
    st_reg.duty[0] == 8'hFF |-> !duty_output[0])
    else $error("Duty FFH did not hold channel 0 low.");

  a_zero_high: assert property ( // RULE8
    st_reg.duty[1] == 8'h00 |-> duty_output[1])
    else $error("Duty 00H did not hold channel 1 high.");

  a_ch0_high: assert property ( // RULE6
    st_reg.duty[0] <= st_reg.cnt |-> duty_output[0])
    else $error("Channel 0 low while duty is at or below counter.");

  a_ch1_low: assert property ( // RULE5
    st_reg.duty[1] > st_reg.cnt |-> !duty_output[1])
    else $error("Channel 1 high while duty exceeds counter.");

  a_ffh_ch1: assert property ( // RULE8
    st_reg.duty[1] == 8'hFF |-> !duty_output[1])
    else $error("Duty FFH did not hold channel 1 low.");

  a_zero_ch0: assert property ( // RULE8
    st_reg.duty[0] == 8'h00 |-> duty_output[0])
    else $error("Duty 00H did not hold channel 0 high.");

  for (genvar g = 0; g < DCP_NCH; g++) begin : g_out_chk
    a_out_match: assert property ( // RULE5 RULE6
      duty_output[g] == !(st_reg.duty[g] > st_reg.cnt))
      else $error("Channel output does not follow its compare.");
  end

  // Register writes. Only the commit edge may change a stored value, so a
  // write that is refused leaves every register as it was.
  a_duty_now: assert property ( // RULE9 RULE7
    commit && pwrite && hit_duty0 && pwdata[7:0] > st_next.cnt
    |=> !duty_output[0] && st_reg.duty[0] == $past(pwdata[7:0]))
    else $error("Duty write did not act on the next edge.");

  a_duty1_now: assert property ( // RULE9 RULE7
    commit && pwrite && hit_duty1 && pwdata[7:0] <= st_next.cnt
    |=> duty_output[1] && st_reg.duty[1] == $past(pwdata[7:0]))
    else $error("Duty write did not reach channel 1 on the next edge.");

  a_reload_write: assert property ( // RULE3
    commit && pwrite && hit_reload |=> st_reg.reload == $past(pwdata[7:0]))
    else $error("Reload write did not land.");

  a_reload_hold: assert property ( // RULE10
    !(commit && pwrite && hit_reload) |=> $stable(st_reg.reload))
    else $error("Reload changed without a write.");

  a_duty_hold: assert property ( // RULE9
    !(commit && pwrite) |=> $stable(st_reg.duty))
    else $error("Duty changed without a write.");

  a_unmapped_wr: assert property (
    commit && pwrite && !mapped |=> $stable(st_reg.duty) && $stable(st_reg.reload))
    else $error("Unmapped write changed a register.");

  // Bus answers. Every transfer gets exactly one wait state, and the answer
  // stands for a single cycle.
  a_read_reload: assert property ( // RULE10
    access && !st_reg.ready && !pwrite && hit_reload
    |=> pready && prdata == {24'h000000, st_reg.reload})
    else $error("Reload read returned something other than the reload.");

  a_read_duty0: assert property ( // RULE7
    access && !st_reg.ready && !pwrite && hit_duty0
    |=> pready && prdata == {24'h000000, st_reg.duty[0]})
    else $error("Channel 0 duty read returned a wrong value.");

  a_read_duty1: assert property ( // RULE7
    access && !st_reg.ready && !pwrite && hit_duty1
    |=> pready && prdata == {24'h000000, st_reg.duty[1]})
    else $error("Channel 1 duty read returned a wrong value.");

  a_bus_answer: assert property (
    access && !st_reg.ready |=> pready ##1 !pready)
    else $error("Slave did not answer one cycle into the access phase.");

  a_unmapped: assert property (
    access && !st_reg.ready && !mapped |=> pslverr && prdata == 32'h0)
    else $error("Unmapped address was not flagged.");

  a_rdata_upper: assert property ( // RULE10
    pready |-> prdata[31:DCP_DW] == 24'h000000)
    else $error("Read data upper bits not zero.");

  a_write_quiet: assert property (
    access && !st_reg.ready && pwrite |=> prdata == 32'h0000_0000)
    else $error("Write answer carried read data.");

  a_ready_only: assert property (
    !access |=> !pready)
    else $error("Ready raised without an access phase.");

  a_err_mapped: assert property (
    access && !st_reg.ready && mapped |=> !pslverr)
    else $error("Mapped address was flagged as an error.");

  a_err_pulse: assert property (
    pslverr |-> pready)
    else $error("Error flag raised without ready.");

  a_ready_gap: assert property (
    pready |=> !pready)
    else $error("Ready stood for more than one cycle.");

  // Main scenarios.
  c_cnt_wrap: cover property (tick && st_reg.cnt == DCP_CNT_LAST);

  c_duty_write: cover property (commit && pwrite && hit_duty1);

  c_reload_read: cover property (commit && !pwrite && hit_reload);

  c_both_low: cover property (duty_output == 2'h0);

endmodule : dcp_pwm

// ===== dv/dcp_filter_model.sv
// Integrating filter model that counts the clocks each channel output spends low.
`timescale 1ns/100ps
////////////////////////////////////////
module dcp_filter_model (
  input wire logic pclk,
  input wire logic clear,
  input wire logic [1:0] pin,
  output int low_cnt [2]
);
  // An integrator only sees the average, so a plain low-time count is all it keeps.
  always @(posedge pclk) begin
    for (int n = 0; n < 2; n++) begin
      low_cnt[n] <= clear ? 0 : low_cnt[n] + int'(pin[n] === 1'b0);
    end
  end
endmodule : dcp_filter_model

// ===== dv/dual_channel_pwm_tb_top.sv
// Self-checking bench for the dual channel pulse width modulator.
`timescale 1ns/100ps
////////////////////////////////////////
module dual_channel_pwm_tb_top;
  import dcp_pkg::*;
`define CHK(got, exp) \
  begin n_checks++; if ((got) !== (exp)) begin fail_count++; \
  $display("wrong value at %0t got %0h", $time, got); end end
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [DCP_AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rdat;
  logic pready, pslverr, rerr, clear = 1'b0;
  logic [DCP_NCH-1:0] duty_output;
  int low_cnt [2];
  int fail_count = 0, n_checks = 0;
  dcp_pwm dcp_pwm_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .duty_output(duty_output));
  dcp_filter_model dcp_filter_model_i (.pclk(pclk), .clear(clear), .pin(duty_output),
    .low_cnt(low_cnt));
  initial begin
    forever #10 pclk = ~pclk;
  end
////////////////////////////////////////
  task automatic final_report;
    $display("checks %0d failures %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report
  // Entered just after a rising edge; leaves one idle edge so psel is never set twice at once.
  task automatic apb(input logic is_wr, input logic [DCP_AW-1:0] a, input logic [31:0] d,
                     output logic [31:0] rd_data, output logic err);
    int i;
    psel <= 1'b1;
    pwrite <= is_wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (pready !== 1'b1) begin
      fail_count++;
      $display("wrong value at %0t no ready", $time);
      final_report();
    end
    rd_data = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [DCP_AW-1:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rdat, rerr);
  endtask : wr
  task automatic rd(input logic [DCP_AW-1:0] a, input logic [31:0] ed, input logic ee);
    apb(1'b0, a, 32'h0000_0000, rdat, rerr);
    `CHK(rdat, ed)
    `CHK(rerr, ee)
  endtask : rd
  // One full period is measured, so the low count is exact whatever the counter phase.
  task automatic measure(input logic [7:0] rl, input logic [7:0] d0, input logic [7:0] d1);
    int per;
    per = DCP_CLK_DIV * (int'(rl) + 1) * DCP_CNT_MOD;
    wr(DCP_ADDR_RELOAD, {24'h00_0000, rl});
    wr(DCP_ADDR_DUTY0, {24'h00_0000, d0});
    wr(DCP_ADDR_DUTY1, {24'h00_0000, d1});
    clear <= 1'b1;
    @(posedge pclk);
    clear <= 1'b0;
    repeat (per) @(posedge pclk);
    #1;
    `CHK(low_cnt[0], per / DCP_CNT_MOD * int'(d0))
    `CHK(low_cnt[1], per / DCP_CNT_MOD * int'(d1))
    @(posedge pclk);
  endtask : measure
////////////////////////////////////////
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK(duty_output, 2'b11)
    rd(DCP_ADDR_RELOAD, 32'h0000_0000, 1'b0);
    rd(DCP_ADDR_DUTY1, 32'h0000_0000, 1'b0);
    wr(DCP_ADDR_RELOAD, 32'h0000_005A);
    rd(DCP_ADDR_RELOAD, 32'h0000_005A, 1'b0);
    rd(12'h3FC, 32'h0000_0000, 1'b1);
    measure(8'h00, 8'h01, 8'hFF);
    measure(8'h01, 8'h00, 8'h80);
    wr(DCP_ADDR_DUTY0, 32'h0000_00FF);
    `CHK(duty_output[0], 1'b0)
    measure(8'h02, 8'hFE, 8'h7F);
    final_report();
  end
endmodule : dual_channel_pwm_tb_top
